//--- hw/rmc_regs.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rmc_defs.svh"

// How it works
// - trim register at index 19h, low five bits read/write, reset zero.
// - upper three bits of the trim register always read zero.
// - trim codes 0..0Fh shift up, 10h..1Fh shift down toward zero.
// - enable register at index 1Ah; trim applies only while enabled.
// - enable bit 0 is read/write, resets zero, one enables margining.
// - enable register bits 7..1 always read zero.
// - half trim at index 1Bh, bits 6..4 pick one of eight raised levels.
// - half trim bit 0 applies the code; clear keeps nominal level.
// - half trim bit 7 reads zero; software writes only zero there.
// - half trim bits 3..1 read zero; software writes only zeros.
// - input pairing register at index 24h, reset zero.
// - common-input register at index 27h.

module rmc_regs
    import rmc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [4:0] REF_TRIM_STEP,
    output logic REF_TRIM_ACTIVE,
    output logic [3:0] HALF_REF_LEVEL,
    output logic [7:0] PAIR_MODE,
    output logic COMMON_PSEUDO_DIFF
);

    // the highest register sits at byte 9Ch
    if (ADDR_W < 8) begin : g_bad_addr_w
        $error("rmc_regs: ADDR_W must be at least 8");
    end

    rmc_regs_t reg_view;
    rmc_trim_t trim;

    logic [7:0] ref_trim_ff;
    logic [7:0] ref_trim_en_ff;
    logic [7:0] half_trim_ff;
    logic [7:0] pairing_ff;
    logic [7:0] common_ff;

    logic aw_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic w_held_ff;
    logic [7:0] w_data_ff;
    logic w_lane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;

    logic aw_take;
    logic w_take;
    logic do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_lane;
    logic wr_hit;
    logic [7:0] wr_index;
    logic rd_take;
    logic rd_hit;
    logic [7:0] rd_value;
    logic [7:0] rd_index;

    logic wr_aligned;
    logic rd_aligned;
    logic wr_sel_ref;
    logic wr_sel_en;
    logic wr_sel_half;
    logic wr_sel_pair;
    logic wr_sel_com;
    logic rd_sel_ref;
    logic rd_sel_en;
    logic rd_sel_half;
    logic rd_sel_pair;
    logic rd_sel_com;
    logic wr_en_ref;
    logic wr_en_en;
    logic wr_en_half;
    logic wr_en_pair;
    logic wr_en_com;
    logic nxt_aw_held;
    logic [ADDR_W-1:0] nxt_aw_addr;
    logic nxt_w_held;
    logic [7:0] nxt_w_data;
    logic nxt_w_lane;
    logic nxt_bvalid;
    logic [1:0] nxt_bresp;
    logic nxt_rvalid;
    logic [1:0] nxt_rresp;
    logic [31:0] nxt_rdata;

    // ---------------- write channel ----------------
    // address and data are caught independently, in either order
    assign S_AXI_AWREADY = !aw_held_ff && !bvalid_ff;
    assign S_AXI_WREADY = !w_held_ff && !bvalid_ff;
    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID && S_AXI_WREADY;

    assign wr_addr = aw_held_ff ? aw_addr_ff : S_AXI_AWADDR;
    assign wr_data = w_held_ff ? w_data_ff : S_AXI_WDATA[7:0];
    assign wr_lane = w_held_ff ? w_lane_ff : S_AXI_WSTRB[0];
    assign do_write = (aw_held_ff || aw_take) && (w_held_ff || w_take);

    // words only; unaligned or out-of-range addresses are unmapped
    assign wr_index = 8'(wr_addr[ADDR_W-1:2]);
    assign wr_aligned = wr_addr[1:0] == 2'h0
        && (wr_addr >> 2) == ADDR_W'(wr_index);

    assign wr_sel_ref = wr_aligned && wr_index == `RMC_IDX_REF_TRIM;
    assign wr_sel_en = wr_aligned && wr_index == `RMC_IDX_REF_TRIM_EN;
    assign wr_sel_half = wr_aligned && wr_index == `RMC_IDX_HALF_TRIM;
    assign wr_sel_pair = wr_aligned && wr_index == `RMC_IDX_PAIRING;
    assign wr_sel_com = wr_aligned && wr_index == `RMC_IDX_COMMON;
    assign wr_hit = wr_sel_ref || wr_sel_en || wr_sel_half
        || wr_sel_pair || wr_sel_com;

    // strobe low still answers okay, but nothing is stored
    assign wr_en_ref = do_write && wr_lane && wr_sel_ref;
    assign wr_en_en = do_write && wr_lane && wr_sel_en;
    assign wr_en_half = do_write && wr_lane && wr_sel_half;
    assign wr_en_pair = do_write && wr_lane && wr_sel_pair;
    assign wr_en_com = do_write && wr_lane && wr_sel_com;

    // a channel taken alone waits here for its partner
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        if (do_write) begin
            nxt_aw_held = 1'b0;
        end else if (aw_take) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = S_AXI_AWADDR;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
        end
    end

    always_comb begin
        nxt_w_held = w_held_ff;
        nxt_w_data = w_data_ff;
        nxt_w_lane = w_lane_ff;
        if (do_write) begin
            nxt_w_held = 1'b0;
        end else if (w_take) begin
            nxt_w_held = 1'b1;
            nxt_w_data = S_AXI_WDATA[7:0];
            nxt_w_lane = S_AXI_WSTRB[0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 8'h00;
            w_lane_ff <= 1'b0;
        end else begin
            w_held_ff <= nxt_w_held;
            w_data_ff <= nxt_w_data;
            w_lane_ff <= nxt_w_lane;
        end
    end

    // a pending answer holds off both write channels until taken
    always_comb begin
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (do_write) begin
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `RMC_RESP_OKAY;
        end else begin
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
        end
    end

    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;

    // ---------------- register storage ----------------
    // only byte lane 0 carries data; reserved bits are masked off
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ref_trim_ff <= `RMC_RST_REF_TRIM;
        end else if (wr_en_ref) begin
            ref_trim_ff <= wr_data & `RMC_MASK_REF_TRIM;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ref_trim_en_ff <= `RMC_RST_REF_TRIM_EN;
        end else if (wr_en_en) begin
            ref_trim_en_ff <= wr_data & `RMC_MASK_REF_TRIM_EN;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            half_trim_ff <= `RMC_RST_HALF_TRIM;
        end else if (wr_en_half) begin
            // nonzero writes to 7 and 3..1 are simply lost
            half_trim_ff <= wr_data & `RMC_MASK_HALF_TRIM;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pairing_ff <= `RMC_RST_PAIRING;
        end else if (wr_en_pair) begin
            pairing_ff <= wr_data & `RMC_MASK_PAIRING;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            common_ff <= `RMC_RST_COMMON;
        end else if (wr_en_com) begin
            common_ff <= wr_data & `RMC_MASK_COMMON;
        end
    end

    // packed view for the trim decoder
    assign reg_view = {ref_trim_ff, ref_trim_en_ff, half_trim_ff,
        pairing_ff, common_ff};

    // ---------------- read channel ----------------
    assign S_AXI_ARREADY = !rvalid_ff;
    assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

    assign rd_index = 8'(S_AXI_ARADDR[ADDR_W-1:2]);
    assign rd_aligned = S_AXI_ARADDR[1:0] == 2'h0
        && (S_AXI_ARADDR >> 2) == ADDR_W'(rd_index);

    assign rd_sel_ref = rd_aligned && rd_index == `RMC_IDX_REF_TRIM;
    assign rd_sel_en = rd_aligned && rd_index == `RMC_IDX_REF_TRIM_EN;
    assign rd_sel_half = rd_aligned && rd_index == `RMC_IDX_HALF_TRIM;
    assign rd_sel_pair = rd_aligned && rd_index == `RMC_IDX_PAIRING;
    assign rd_sel_com = rd_aligned && rd_index == `RMC_IDX_COMMON;
    assign rd_hit = rd_sel_ref || rd_sel_en || rd_sel_half
        || rd_sel_pair || rd_sel_com;

    // nothing selected leaves zero, so misses read back 0
    always_comb begin
        rd_value = 8'h00;
        if (rd_sel_ref) begin
            rd_value = ref_trim_ff;
        end
        if (rd_sel_en) begin
            rd_value = ref_trim_en_ff;
        end
        if (rd_sel_half) begin
            rd_value = half_trim_ff;
        end
        if (rd_sel_pair) begin
            rd_value = pairing_ff;
        end
        if (rd_sel_com) begin
            rd_value = common_ff;
        end
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (rd_take) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = rd_hit ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
            nxt_rdata = {24'h000000, rd_value};
        end else if (S_AXI_RREADY) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= `RMC_RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign S_AXI_RDATA = rdata_ff;

    // ---------------- effective trim settings ----------------
    // one cycle behind the registers so outputs come from flip-flops
    rmc_trim_map u_map (
        .clk(SYS_CLK),
        .rst(RST),
        .regs(reg_view),
        .trim(trim),
        .pair_mode(PAIR_MODE)
    );

    assign REF_TRIM_STEP = trim.ref_step;
    assign REF_TRIM_ACTIVE = trim.ref_active;
    assign HALF_REF_LEVEL = trim.half_level;
    assign COMMON_PSEUDO_DIFF = trim.common_pseudo_diff;

endmodule

//--- hw/rmc_defs.svh
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH

// register indexes; byte address is four times the index
`define RMC_IDX_REF_TRIM 8'h19
`define RMC_IDX_REF_TRIM_EN 8'h1A
`define RMC_IDX_HALF_TRIM 8'h1B
`define RMC_IDX_PAIRING 8'h24
`define RMC_IDX_COMMON 8'h27

// writable bit masks, everything else reads zero
`define RMC_MASK_REF_TRIM 8'h1F
`define RMC_MASK_REF_TRIM_EN 8'h01
`define RMC_MASK_HALF_TRIM 8'h71
`define RMC_MASK_PAIRING 8'hFF
`define RMC_MASK_COMMON 8'h01

// reset values
`define RMC_RST_REF_TRIM 8'h00
`define RMC_RST_REF_TRIM_EN 8'h00
`define RMC_RST_HALF_TRIM 8'h00
`define RMC_RST_PAIRING 8'h00
`define RMC_RST_COMMON 8'h00

// field positions
`define RMC_REF_CODE_LSB 0
`define RMC_REF_CODE_MSB 4
`define RMC_REF_ON_BIT 0
`define RMC_HALF_ON_BIT 0
`define RMC_HALF_CODE_LSB 4
`define RMC_HALF_CODE_MSB 6
`define RMC_COMMON_BIT 0

// answers on the register bus
`define RMC_RESP_OKAY 2'h0
`define RMC_RESP_SLVERR 2'h2

`endif

//--- hw/rmc_pkg.sv
package rmc_pkg;

    typedef struct packed {
        logic [7:0] ref_trim;
        logic [7:0] ref_trim_en;
        logic [7:0] half_trim;
        logic [7:0] pairing;
        logic [7:0] common;
    } rmc_regs_t;

    typedef enum logic [1:0] {
        RMC_PAIR_SEPARATE,
        RMC_PAIR_SINGLE_ENDED,
        RMC_PAIR_PSEUDO_DIFF
    } rmc_pair_t;

    typedef struct packed {
        logic [4:0] ref_step;
        logic ref_active;
        logic [3:0] half_level;
        logic common_pseudo_diff;
    } rmc_trim_t;

endpackage

//--- hw/rmc_trim_map.sv
`timescale 1ns/100ps
`include "rmc_defs.svh"

module rmc_trim_map
    import rmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input rmc_regs_t regs,
    output rmc_trim_t trim,
    output logic [7:0] pair_mode
);

    rmc_trim_t nxt_trim;
    rmc_trim_t trim_ff;
    logic [7:0] nxt_pair_mode;
    logic [7:0] pair_mode_ff;
    logic [4:0] ref_code;
    logic [2:0] half_code;

    assign ref_code = regs.ref_trim[`RMC_REF_CODE_MSB:`RMC_REF_CODE_LSB];
    assign half_code = regs.half_trim[`RMC_HALF_CODE_MSB:`RMC_HALF_CODE_LSB];

    always_comb begin
        nxt_trim = '0;
        // two's complement code: 10000b is the largest negative shift
        nxt_trim.ref_active = regs.ref_trim_en[`RMC_REF_ON_BIT];
        if (nxt_trim.ref_active) begin
            nxt_trim.ref_step = ref_code;
        end
        // level 0 is nominal, 1..8 are the raised levels
        if (regs.half_trim[`RMC_HALF_ON_BIT]) begin
            nxt_trim.half_level = {1'b0, half_code} + 4'h1;
        end
        nxt_trim.common_pseudo_diff = regs.common[`RMC_COMMON_BIT];
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pair
            logic [1:0] pair_field;
            assign pair_field = regs.pairing[2*g+1:2*g];
            // 11b behaves as two separate channels
            assign nxt_pair_mode[2*g+1:2*g] = (pair_field == 2'h3)
                ? 2'(RMC_PAIR_SEPARATE) : pair_field;
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trim_ff <= '0;
        end else begin
            trim_ff <= nxt_trim;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pair_mode_ff <= 8'h00;
        end else begin
            pair_mode_ff <= nxt_pair_mode;
        end
    end

    assign trim = trim_ff;
    assign pair_mode = pair_mode_ff;

endmodule

//--- dv/rmc_regs_sva.sv
`timescale 1ns/100ps
module rmc_regs_sva (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [4:0] REF_TRIM_STEP,
    input wire logic REF_TRIM_ACTIVE,
    input wire logic [3:0] HALF_REF_LEVEL
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
        else $error("write answer late");
    rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID) else $error("read answer late");
    b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
    r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
    aw_block_a: assert property (S_AXI_BVALID
        |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write not blocked");
    rd_hi_a: assert property (S_AXI_RVALID
        |-> S_AXI_RDATA[31:8] == 24'h0) else $error("upper read bits set");
    step_off_a: assert property (!REF_TRIM_ACTIVE
        |-> REF_TRIM_STEP == 5'h0) else $error("trim applied while off");
    half_max_a: assert property (HALF_REF_LEVEL <= 4'h8)
        else $error("half level out of range");
    cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
    cover property (REF_TRIM_ACTIVE && REF_TRIM_STEP != 5'h0);
    cover property (HALF_REF_LEVEL == 4'h8);
endmodule

//--- dv/tb_rmc_regs.sv
`timescale 1ns/100ps
module tb_rmc_regs;
    import rmc_pkg::*;
    typedef struct packed {
        logic [7:0] i;
        logic [7:0] w;
        logic [7:0] e;
    } rmc_row_t;
    logic SYS_CLK = 0, RST = 1;
    logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, d;
    logic [3:0] S_AXI_WSTRB = 0, HALF_REF_LEVEL;
    logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, REF_TRIM_ACTIVE;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, COMMON_PSEUDO_DIFF;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    logic [4:0] REF_TRIM_STEP;
    logic [7:0] PAIR_MODE;
    int n_mismatch = 0, n_compared = 0;
    rmc_row_t rows [5] = '{
        '{8'h19, 8'hFF, 8'h1F},
        '{8'h1A, 8'hFF, 8'h01},
        '{8'h1B, 8'h71, 8'h71},
        '{8'h24, 8'hA5, 8'hA5},
        '{8'h27, 8'hFF, 8'h01}
    };
    rmc_regs dut_u (.*);
    always #5 SYS_CLK = ~SYS_CLK;
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    // a hung handshake must still reach the verdict
    task automatic tmo(input int n);
        if (n > 40) begin
            n_mismatch++;
            $display("[FAIL] handshake exp answer got none");
            end_sim();
        end
    endtask
    function automatic logic [7:0] ba(input logic [7:0] i);
        return i << 2;
    endfunction
    // ready is sampled 1 ns after the edge, once the inputs have settled
    task automatic wr(input logic [7:0] a, d8, input logic [3:0] s);
        logic ta, tw, ga, gw;
        int n;
        ga = 0;
        gw = 0;
        n = 0;
        @(posedge SYS_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h0, d8};
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1;
        S_AXI_WVALID <= 1;
        S_AXI_BREADY <= 1;
        while (!(ga && gw)) begin
            #1 ta = S_AXI_AWVALID && S_AXI_AWREADY === 1'b1;
            tw = S_AXI_WVALID && S_AXI_WREADY === 1'b1;
            @(posedge SYS_CLK);
            if (ta)
                S_AXI_AWVALID <= 0;
            if (tw)
                S_AXI_WVALID <= 0;
            ga |= ta;
            gw |= tw;
            tmo(++n);
        end
        ta = 0;
        while (!ta) begin
            #1 ta = S_AXI_BVALID === 1'b1;
            r = S_AXI_BRESP;
            @(posedge SYS_CLK);
            tmo(++n);
        end
        S_AXI_BREADY <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic t;
        int n;
        t = 0;
        n = 0;
        @(posedge SYS_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1;
        S_AXI_RREADY <= 1;
        while (!t) begin
            #1 t = S_AXI_ARREADY === 1'b1;
            @(posedge SYS_CLK);
            tmo(++n);
        end
        S_AXI_ARVALID <= 0;
        t = 0;
        while (!t) begin
            #1 t = S_AXI_RVALID === 1'b1;
            d = S_AXI_RDATA;
            r = S_AXI_RRESP;
            @(posedge SYS_CLK);
            tmo(++n);
        end
        S_AXI_RREADY <= 0;
    endtask
    // effective outputs lag the registers by one clock
    task automatic settle();
        repeat (2) @(posedge SYS_CLK);
        #1;
    endtask
    initial begin
        repeat (4) @(posedge SYS_CLK);
        RST <= 0;
        foreach (rows[k]) begin
            rd(ba(rows[k].i));
            chk("reset value", 32'h0, d);
            wr(ba(rows[k].i), rows[k].w, 4'hF);
            chk("bresp", 32'h0, {30'h0, r});
            rd(ba(rows[k].i));
            chk("readback", {24'h0, rows[k].e}, d);
        end
        $display("test rows done");
        settle();
        chk("step", 32'h1F, {27'h0, REF_TRIM_STEP});
        chk("active", 32'h1, {31'h0, REF_TRIM_ACTIVE});
        chk("half", 32'h8, {28'h0, HALF_REF_LEVEL});
        chk("pair", 32'hA5, {24'h0, PAIR_MODE});
        chk("common", 32'h1, {31'h0, COMMON_PSEUDO_DIFF});
        wr(ba(8'h19), 8'h10, 4'hF);
        settle();
        chk("step min", 32'h10, {27'h0, REF_TRIM_STEP});
        wr(ba(8'h1A), 8'h00, 4'hF);
        wr(ba(8'h1B), 8'h01, 4'hF);
        wr(ba(8'h24), 8'hFF, 4'hF);
        settle();
        chk("step off", 32'h0, {27'h0, REF_TRIM_STEP});
        chk("active off", 32'h0, {31'h0, REF_TRIM_ACTIVE});
        chk("half low", 32'h1, {28'h0, HALF_REF_LEVEL});
        chk("pair 11b", 32'h0, {24'h0, PAIR_MODE});
        wr(ba(8'h1B), 8'h70, 4'hF);
        settle();
        chk("half off", 32'h0, {28'h0, HALF_REF_LEVEL});
        $display("test outputs done");
        wr(ba(8'h19), 8'h05, 4'h0);
        chk("strb resp", 32'h0, {30'h0, r});
        rd(ba(8'h19));
        chk("strb keep", 32'h10, d);
        wr(8'h80, 8'hFF, 4'hF);
        chk("unmapped wr", 32'h2, {30'h0, r});
        rd(8'h65);
        chk("unaligned rd", 32'h2, {30'h0, r});
        chk("unaligned data", 32'h0, d);
        $display("test refusals done");
        RST <= 1;
        repeat (2) @(posedge SYS_CLK);
        RST <= 0;
        rd(ba(8'h19));
        chk("reset again", 32'h0, d);
        settle();
        chk("half reset", 32'h0, {28'h0, HALF_REF_LEVEL});
        $display("test reset done");
        end_sim();
    end
endmodule
bind rmc_regs rmc_regs_sva sva_u (.*);
